// ==== hw/mcl_pkg.sv ====
package mcl_pkg;

  // Digital inputs, source selection and speed width
  localparam int unsigned DI_COUNT = 8;
  localparam int unsigned SRC_W    = 3;
  localparam int unsigned SPD_W    = 16;
  localparam int unsigned SET_W    = 2;

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned MS_IN_NS        = 1000000;
  localparam int unsigned MS_CYCLES       = MS_IN_NS / CLK_PERIOD_NS;
  localparam int unsigned SET_SWITCH_MS   = 4;
  localparam int unsigned SET_SWITCH_CYC  = SET_SWITCH_MS * MS_CYCLES;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_JOG_ONE   = 8'h04;
  localparam logic [7:0] OFS_JOG_TWO   = 8'h08;
  localparam logic [7:0] OFS_CEILING   = 8'h0C;
  localparam logic [7:0] OFS_RAMP_UP   = 8'h10;
  localparam logic [7:0] OFS_RAMP_DOWN = 8'h14;
  localparam logic [7:0] OFS_RUN_SPEED = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_SRC_BASE  = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_PRESET_LSB = 0;
  localparam int unsigned CTRL_COUNT_LSB  = 8;
  localparam int unsigned CTRL_NEGATE_BIT = 11;
  localparam int unsigned CTRL_NEGBLK_BIT = 12;
  localparam int unsigned CTRL_POSBLK_BIT = 13;
  localparam int unsigned CTRL_SEL0_LSB   = 16;
  localparam int unsigned CTRL_SEL1_LSB   = 20;
  localparam int unsigned CTRL_JOG1_LSB   = 24;
  localparam int unsigned CTRL_JOG2_LSB   = 28;

  // Source set register fields
  localparam int unsigned SRC_CMD1_LSB = 0;
  localparam int unsigned SRC_CMD2_LSB = 4;
  localparam int unsigned SRC_CMD3_LSB = 8;

  // Values after reset, plus the three-wire preset code and the set count limits
  localparam logic [7:0]       PRESET_THREE_WIRE = 8'h14;
  localparam logic [7:0]       PRESET_RST        = 8'h14;
  localparam logic [2:0]       SET_COUNT_RST     = 3'h2;
  localparam logic [2:0]       SET_COUNT_MIN     = 3'h2;
  localparam logic [2:0]       SET_COUNT_MAX     = 3'h4;
  localparam logic [SRC_W-1:0] JOG1_SRC_RST      = 3'h0;
  localparam logic [SRC_W-1:0] JOG2_SRC_RST      = 3'h1;
  localparam logic [SRC_W-1:0] SEL0_SRC_RST      = 3'h6;
  localparam logic [SRC_W-1:0] SEL1_SRC_RST      = 3'h7;
  localparam logic [11:0]      SRC_SET_RST       = 12'h210;
  localparam logic [SPD_W-1:0] JOG_ONE_RST       = 16'h0096;
  localparam logic [SPD_W-1:0] JOG_TWO_RST       = 16'hFF6A;
  localparam logic [SPD_W-1:0] CEILING_RST       = 16'h05DC;
  localparam logic [SPD_W-1:0] RAMP_UP_MS_RST    = 16'h2710;
  localparam logic [SPD_W-1:0] RAMP_DOWN_MS_RST  = 16'h2710;
  localparam logic [SPD_W-1:0] RUN_SPEED_RST     = 16'h03E8;

  typedef enum logic [1:0] {MCL_OFF, MCL_RUN, MCL_JOG} mcl_state_e;

  // Three routed control commands
  typedef struct packed {
    logic enable;
    logic on;
    logic reverse;
  } mcl_cmd_s;

  // Ramp settings
  typedef struct packed {
    logic [SPD_W-1:0] ceiling;
    logic [SPD_W-1:0] up_ms;
    logic [SPD_W-1:0] down_ms;
  } mcl_ramp_cfg_s;

endpackage

// ==== hw/mcl_ramp.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcl_ramp
  import mcl_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  // Millisecond enable and target
  input  wire logic                    ms_tick_i,
  input  wire logic signed [SPD_W-1:0] target_i,
  input  wire mcl_ramp_cfg_s           cfg_i,
  // Ramp output
  output logic signed [SPD_W-1:0]      speed_o
);
  logic        [31:0] acc;
  logic        [31:0] next_acc;
  logic signed [SPD_W-1:0] next_speed;

  // Away from zero uses the up time, toward zero the down time
  wire         rising   = (target_i > speed_o);
  wire         away     = rising ? (speed_o >= 0) : (speed_o <= 0);
  wire  [31:0] ramp_ms  = {16'h0000, away ? cfg_i.up_ms : cfg_i.down_ms};
  wire  [31:0] tick_add = ms_tick_i ? {16'h0000, cfg_i.ceiling} : 32'h00000000;
  wire         at_goal  = (target_i == speed_o);
  wire         do_step  = !at_goal && (acc >= ramp_ms);

  // One rpm step each time a ceiling-per-ramp-time share is accumulated
  always_comb
  begin
    next_acc   = acc + tick_add;
    next_speed = speed_o;
    if (at_goal)
    begin
      next_acc = 32'h00000000;
    end
    else if (do_step)
    begin
      next_acc   = acc - ramp_ms + tick_add;
      next_speed = rising ? speed_o + 16'sh0001 : speed_o - 16'sh0001;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      acc     <= 32'h00000000;
      speed_o <= 16'sh0000;
    end
    else
    begin
      acc     <= next_acc;
      speed_o <= next_speed;
    end
  end

  chk_ramp_step_one: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (speed_o - $past(speed_o) <= 16'sh0001) && ($past(speed_o) - speed_o <= 16'sh0001))
    else $error("ramp moved by more than one step");

endmodule
`default_nettype wire

// ==== hw/mcl_core.sv ====
// Operation
// - Enable low forces a ramp stop whatever ON and reversing show; the code still lets a jog level run the motor with enable low.
// - With enable high, only a rising ON edge starts the motor.
// - Reversing level at start sets direction: low clockwise, high counter-clockwise.
// - Wiring preset 20 takes enable, ON, reversing from inputs 0, 1, 2.
// - Each command's input is selectable per command set.
// - Jog input level runs motor toward the selected jog speed; the code ignores jog levels under wiring preset 20.
// - Two jog speeds, defaults 150 and -150 rpm.
// - Jog uses the shared ramp; up and down times default 10 s.
// - Jog only from ready state; ignored while the motor runs.
// - Jog one defaults to input 0, jog two to input 1.
// - Two direction blocks: 1 blocks negative or positive rotation.
// - Setpoint negation flips the setpoint sign when set.
// - Speed ceiling defaults to 1500 rpm and limits the command.
// - Active command set chosen by selector wired to any input.
// - Command set change completes in about 4 ms.
// - Number of command sets is 2, 3 or 4, default 2.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module mcl_core
  import mcl_pkg::*;
#(
  parameter int unsigned MS_CYC     = MS_CYCLES,
  parameter int unsigned SWITCH_CYC = SET_SWITCH_CYC
)
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 nrst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Digital inputs
  input  wire logic [DI_COUNT-1:0]  digital_input_i,
  // Motor command
  output logic                      motor_on_o,
  output logic                      motor_ccw_o,
  output logic                      ramp_stop_command_o,
  output logic signed [SPD_W-1:0]   speed_command_o
);
  // Settings
  logic [31:0]      ctrl;
  logic [SPD_W-1:0] jog_speed_one;
  logic [SPD_W-1:0] jog_speed_two;
  logic [SPD_W-1:0] speed_ceiling;
  logic [SPD_W-1:0] ramp_up_time;
  logic [SPD_W-1:0] ramp_down_time;
  logic [SPD_W-1:0] run_speed;
  logic [11:0]      src_set [4];

  // Sampled inputs and state
  logic [DI_COUNT-1:0] di_q;
  logic                on_prev;
  mcl_state_e          state;
  mcl_state_e          next_state;
  logic                jog_two_sel;
  logic [SET_W-1:0]    command_set_index;
  logic [31:0]         switch_cnt;
  logic [31:0]         ms_cnt;
  logic                ms_tick;
  logic signed [SPD_W-1:0] ramp_speed;

  // Control register fields
  wire [7:0]       wiring_preset_select = ctrl[CTRL_PRESET_LSB +: 8];
  wire [2:0]       command_set_count    = ctrl[CTRL_COUNT_LSB +: 3];
  wire             setpoint_negate      = ctrl[CTRL_NEGATE_BIT];
  wire             neg_dir_block        = ctrl[CTRL_NEGBLK_BIT];
  wire             pos_dir_block        = ctrl[CTRL_POSBLK_BIT];
  wire [SRC_W-1:0] sel0_source          = ctrl[CTRL_SEL0_LSB +: SRC_W];
  wire [SRC_W-1:0] sel1_source          = ctrl[CTRL_SEL1_LSB +: SRC_W];
  wire [SRC_W-1:0] jog_one_source       = ctrl[CTRL_JOG1_LSB +: SRC_W];
  wire [SRC_W-1:0] jog_two_source       = ctrl[CTRL_JOG2_LSB +: SRC_W];

  // Wishbone decode
  // A request is taken only while ack is low, so each access gets exactly one ack
  wire        wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr     = wb_req && wb_we_i;
  wire [7:0]  adr_w     = {wb_adr_i[7:2], 2'b00};
  wire        hit_src   = (adr_w >= OFS_SRC_BASE) && (adr_w < OFS_SRC_BASE + 8'h10);
  wire [1:0]  src_idx   = adr_w[3:2];
  wire [31:0] bmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] half_mask = bmask[15:0];
  wire [15:0] half_dat  = wb_dat_i[15:0] & half_mask;
  wire [31:0] wr_ctrl   = (ctrl & ~bmask) | (wb_dat_i & bmask);
  // An out-of-range set count keeps the old count while the other fields still land
  wire [2:0]  cnt_wr    = wr_ctrl[CTRL_COUNT_LSB +: 3];
  wire        cnt_ok    = (cnt_wr >= SET_COUNT_MIN) && (cnt_wr <= SET_COUNT_MAX);
  wire [31:0] ctrl_new  = cnt_ok ? wr_ctrl : {wr_ctrl[31:11], command_set_count, wr_ctrl[7:0]};
  wire [31:0] src_new   = ({20'h00000, src_set[src_idx]} & ~bmask) | (wb_dat_i & bmask);

  // Active source set
  wire [11:0]      act_src  = src_set[command_set_index];
  wire [SRC_W-1:0] src_cmd1 = act_src[SRC_CMD1_LSB +: SRC_W];
  wire [SRC_W-1:0] src_cmd2 = act_src[SRC_CMD2_LSB +: SRC_W];
  wire [SRC_W-1:0] src_cmd3 = act_src[SRC_CMD3_LSB +: SRC_W];

  // Command routing, fixed wiring under the three-wire preset
  wire      preset_fixed = (wiring_preset_select == PRESET_THREE_WIRE);
  mcl_cmd_s cmd;
  assign cmd.enable  = preset_fixed ? di_q[0] : di_q[src_cmd1];
  assign cmd.on      = preset_fixed ? di_q[1] : di_q[src_cmd2];
  assign cmd.reverse = preset_fixed ? di_q[2] : di_q[src_cmd3];

  wire on_rise   = cmd.on && !on_prev;
  wire jog_one   = di_q[jog_one_source];
  wire jog_two   = di_q[jog_two_source];
  // The three-wire preset claims inputs 0 to 2, so jog is live only with routed commands
  wire jog_level = !preset_fixed && (jog_one || jog_two);

  // Requested command set from the selector inputs, limited to the count
  wire [SET_W-1:0] sel_raw   = {di_q[sel1_source], di_q[sel0_source]};
  wire [2:0]       sel_wide  = {1'b0, sel_raw};
  wire [SET_W-1:0] set_limit = SET_W'(command_set_count - 3'h1);
  wire [SET_W-1:0] set_req   = (sel_wide >= command_set_count) ? set_limit : sel_raw;
  // The request must differ from the active set for the whole switch time before the set changes
  wire             switching = (set_req != command_set_index);
  wire             switch_done = switching && (switch_cnt == SWITCH_CYC - 1);

  // Motor sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      MCL_OFF:
      begin
        if (cmd.enable && on_rise)
          next_state = MCL_RUN;
        else if (jog_level)
          next_state = MCL_JOG;
      end
      MCL_RUN:
      begin
        if (!cmd.enable)
          next_state = MCL_OFF;
      end
      MCL_JOG:
      begin
        if (!jog_level)
          next_state = MCL_OFF;
      end
      default:
        next_state = MCL_OFF;
    endcase
  end

  // Setpoint chain: source, negation, ceiling, direction blocks
  wire signed [SPD_W-1:0] run_sp   = motor_ccw_o ? -$signed(run_speed) : $signed(run_speed);
  wire signed [SPD_W-1:0] jog_sp   = jog_two_sel ? $signed(jog_speed_two) : $signed(jog_speed_one);
  wire signed [SPD_W-1:0] raw_sp   = (state == MCL_RUN) ? run_sp : (state == MCL_JOG) ? jog_sp : 16'sh0000;
  wire signed [SPD_W-1:0] inv_sp   = setpoint_negate ? -raw_sp : raw_sp;
  wire signed [SPD_W-1:0] ceil_pos = $signed(speed_ceiling);
  wire signed [SPD_W-1:0] lim_sp   = (inv_sp > ceil_pos) ? ceil_pos : (inv_sp < -ceil_pos) ? -ceil_pos : inv_sp;
  wire blocked = (neg_dir_block && lim_sp < 0) || (pos_dir_block && lim_sp > 0);
  wire signed [SPD_W-1:0] target   = blocked ? 16'sh0000 : lim_sp;

  mcl_ramp_cfg_s ramp_cfg;
  assign ramp_cfg.ceiling = speed_ceiling;
  assign ramp_cfg.up_ms   = ramp_up_time;
  assign ramp_cfg.down_ms = ramp_down_time;

  mcl_ramp u_ramp (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ms_tick_i (ms_tick),
    .target_i  (target),
    .cfg_i     (ramp_cfg),
    .speed_o   (ramp_speed)
  );

  // One-cycle millisecond enable for the ramp
  assign ms_tick = (ms_cnt == MS_CYC - 1);

  // Read mux
  wire [31:0] status = {ramp_speed, 11'h000, switching, command_set_index, motor_ccw_o, motor_on_o};
  wire [31:0] rd_data =
    (adr_w == OFS_CTRL)      ? ctrl :
    (adr_w == OFS_JOG_ONE)   ? {16'h0000, jog_speed_one} :
    (adr_w == OFS_JOG_TWO)   ? {16'h0000, jog_speed_two} :
    (adr_w == OFS_CEILING)   ? {16'h0000, speed_ceiling} :
    (adr_w == OFS_RAMP_UP)   ? {16'h0000, ramp_up_time} :
    (adr_w == OFS_RAMP_DOWN) ? {16'h0000, ramp_down_time} :
    (adr_w == OFS_RUN_SPEED) ? {16'h0000, run_speed} :
    (adr_w == OFS_STATUS)    ? status :
    hit_src                  ? {20'h00000, src_set[src_idx]} : 32'h00000000;

  // Bus slave and settings
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h00000000;
      ctrl           <= {1'b0, JOG2_SRC_RST, 1'b0, JOG1_SRC_RST, 1'b0, SEL1_SRC_RST, 1'b0, SEL0_SRC_RST,
                         5'h00, SET_COUNT_RST, PRESET_RST};
      jog_speed_one  <= JOG_ONE_RST;
      jog_speed_two  <= JOG_TWO_RST;
      speed_ceiling  <= CEILING_RST;
      ramp_up_time   <= RAMP_UP_MS_RST;
      ramp_down_time <= RAMP_DOWN_MS_RST;
      run_speed      <= RUN_SPEED_RST;
      for (int i = 0; i < 4; i++)
        src_set[i] <= SRC_SET_RST;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h00000000;
      if (wb_wr && adr_w == OFS_CTRL)      ctrl           <= ctrl_new;
      if (wb_wr && adr_w == OFS_JOG_ONE)   jog_speed_one  <= half_dat | (jog_speed_one & ~half_mask);
      if (wb_wr && adr_w == OFS_JOG_TWO)   jog_speed_two  <= half_dat | (jog_speed_two & ~half_mask);
      if (wb_wr && adr_w == OFS_CEILING)   speed_ceiling  <= half_dat | (speed_ceiling & ~half_mask);
      if (wb_wr && adr_w == OFS_RAMP_UP)   ramp_up_time   <= half_dat | (ramp_up_time & ~half_mask);
      if (wb_wr && adr_w == OFS_RAMP_DOWN) ramp_down_time <= half_dat | (ramp_down_time & ~half_mask);
      if (wb_wr && adr_w == OFS_RUN_SPEED) run_speed      <= half_dat | (run_speed & ~half_mask);
      if (wb_wr && hit_src)                src_set[src_idx] <= src_new[11:0];
    end
  end

  // Motor state, inputs and set switch timer
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      di_q              <= '0;
      on_prev           <= 1'b0;
      state             <= MCL_OFF;
      motor_ccw_o       <= 1'b0;
      jog_two_sel       <= 1'b0;
      command_set_index <= '0;
      switch_cnt        <= 32'h00000000;
      ms_cnt            <= 32'h00000000;
    end
    else
    begin
      di_q    <= digital_input_i;
      on_prev <= cmd.on;
      state   <= next_state;
      ms_cnt  <= ms_tick ? 32'h00000000 : ms_cnt + 32'h00000001;
      if (state == MCL_OFF && next_state == MCL_RUN)
        motor_ccw_o <= cmd.reverse;
      if (state == MCL_OFF && next_state == MCL_JOG)
        jog_two_sel <= !jog_one;
      switch_cnt <= (switching && !switch_done) ? switch_cnt + 32'h00000001 : 32'h00000000;
      if (switch_done)
        command_set_index <= set_req;
    end
  end

  assign motor_on_o          = (state != MCL_OFF);
  assign ramp_stop_command_o = (state == MCL_OFF);
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      speed_command_o <= 16'sh0000;
    else
      speed_command_o <= ramp_speed;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_enable_stops_run: assert property ((state == MCL_RUN && !cmd.enable) |=> ramp_stop_command_o)
    else $error("run did not stop on enable low");
  chk_start_needs_edge: assert property ((state == MCL_OFF && cmd.on && on_prev) |=> state != MCL_RUN)
    else $error("motor started without an ON edge");
  chk_start_direction: assert property ((state == MCL_OFF && next_state == MCL_RUN) |=>
    motor_ccw_o == $past(cmd.reverse))
    else $error("direction not taken from reversing at start");
  chk_preset_routing: assert property (preset_fixed |-> cmd.enable == di_q[0] && cmd.on == di_q[1])
    else $error("preset routing wrong");
  chk_jog_ignored: assert property ((state == MCL_RUN && cmd.enable) |=> state == MCL_RUN)
    else $error("jog disturbed a running motor");
  chk_dir_blocks: assert property ((neg_dir_block |-> target >= 0) and (pos_dir_block |-> target <= 0))
    else $error("blocked direction commanded");
  chk_ceiling_limit: assert property (target <= ceil_pos && target >= -ceil_pos)
    else $error("target beyond ceiling");
  chk_set_switch_time: assert property ($changed(command_set_index) |-> $past(switch_cnt) == SWITCH_CYC - 1)
    else $error("command set switched at wrong time");
  chk_set_in_range: assert property ({1'b0, command_set_index} < command_set_count)
    else $error("command set beyond count");

  chk_enable_low_off: assert property ((state == MCL_OFF && !cmd.enable) |=> state != MCL_RUN)
    else $error("motor started with enable low");
  chk_jog_from_off: assert property ((state == MCL_OFF && jog_level && !cmd.enable) |=> state == MCL_JOG)
    else $error("jog level did not switch the motor on");
  chk_jog_stops: assert property ((state == MCL_JOG && !jog_level) |=> state == MCL_OFF)
    else $error("jog did not stop when its input fell");
  chk_speed_follows_ramp: assert property (speed_command_o == $past(ramp_speed))
    else $error("speed command does not follow the ramp");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held for more than one cycle");
  chk_dat_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside the acknowledge cycle");

  // Main scenarios
  cov_run_start: cover property (state == MCL_OFF ##1 state == MCL_RUN);
  cov_jog_run:   cover property (state == MCL_OFF ##1 state == MCL_JOG);
  cov_set_swap:  cover property ($changed(command_set_index));
  cov_routed_run: cover property (!preset_fixed && state == MCL_OFF ##1 state == MCL_RUN);
  cov_jog_two:   cover property (state == MCL_JOG && jog_two_sel);

endmodule
`default_nettype wire

// ==== tb/mcl_di_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcl_di_model
  import mcl_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  // Requested levels and device state
  input  wire logic [DI_COUNT-1:0] req_i,
  input  wire logic [DI_COUNT-1:0] jog_mask_i,
  input  wire logic                force_jog_i,
  input  wire logic                motor_on_i,
  // Digital inputs of the device
  output logic      [DI_COUNT-1:0] digital_input_o
);
  // A new jog level is held back while the motor already runs, unless forced
  wire logic [DI_COUNT-1:0] held;
  assign held = jog_mask_i & ~digital_input_o & {DI_COUNT{motor_on_i & ~force_jog_i}};
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      digital_input_o <= '0;
    else
      digital_input_o <= req_i & ~held;
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import mcl_pkg::*;
;
  logic                    ref_clk = 1'b0;
  logic                    nrst = 1'b0;
  logic                    cyc = 1'b0;
  logic                    stb = 1'b0;
  logic                    we = 1'b0;
  logic [7:0]              adr = 8'h00;
  logic [3:0]              sel = 4'h0;
  logic [31:0]             wdat = 32'h0;
  logic [DI_COUNT-1:0]     req = 8'h00;
  logic [DI_COUNT-1:0]     jog_mask = 8'h00;
  logic                    force_jog = 1'b0;
  logic                    st_prev = 1'b0;
  wire logic [31:0]        rdat;
  wire logic               ack;
  wire logic [DI_COUNT-1:0] di;
  wire logic               mon;
  wire logic               mccw;
  wire logic               mstop;
  wire logic signed [15:0] spd;
  int                      n_errors = 0;
  int                      n_checks = 0;
  int                      cycles = 0;
  logic [63:0]             rd_q[$];
  logic [63:0]             rd_e;
  logic [3:0]              st_q[$];

  always #2 ref_clk = ~ref_clk;

  mcl_core #(.MS_CYC(10), .SWITCH_CYC(20)) uut (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .digital_input_i(di), .motor_on_o(mon), .motor_ccw_o(mccw),
    .ramp_stop_command_o(mstop), .speed_command_o(spd));

  mcl_di_model partner (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .req_i(req), .jog_mask_i(jog_mask),
    .force_jog_i(force_jog), .motor_on_i(mon), .digital_input_o(di));

  task automatic results;
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Read entries hold {mask, value}; motor entries {ccw_care, on, stop, ccw}
  task automatic cmp_rd(input logic [63:0] e);
    n_checks++;
    if ((rdat & e[63:32]) !== e[31:0])
    begin
      n_errors++;
      $display("unexpected read data at %h: expected %h seen %h", adr, e[31:0], rdat & e[63:32]);
    end
  endtask

  task automatic cmp_st(input logic [3:0] e);
    n_checks++;
    if ({mon, mstop} !== e[2:1] || (e[3] && mccw !== e[0]))
    begin
      n_errors++;
      $display("unexpected motor state: expected %b seen %b", e[2:0], {mon, mstop, mccw});
    end
  endtask

  task automatic cmp_spd(input logic [15:0] e);
    n_checks++;
    if (spd !== e)
    begin
      n_errors++;
      $display("unexpected speed command: expected %h seen %h", e, spd);
    end
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      results;
    end
    else
    begin
      if (ack === 1'b1 && we === 1'b0)
      begin
        rd_e = rd_q.size() > 0 ? rd_q.pop_front() : 64'h1;
        cmp_rd(rd_e);
        if (adr == OFS_STATUS && rd_e[63:48] == 16'hFFFF)
          cmp_spd(rd_e[31:16]);
      end
      if (nrst && mon !== st_prev)
      begin
        st_prev = mon;
        cmp_st(st_q.size() > 0 ? st_q.pop_front() : 4'b0110);
      end
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do
    begin
      @(posedge ref_clk);
    end
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e});
    wb(1'b0, a, 32'h0);
  endtask

  task automatic drv(input logic [7:0] b);
    @(posedge ref_clk);
    req <= b;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic st(input logic care, input logic on, input logic ccw);
    st_q.push_back({care, on, ~on, ccw});
  endtask

  // Jog on, check ramped speed, jog off and let it ramp back
  task automatic jog(input logic [7:0] b, input int n, input logic [15:0] e);
    st(1'b0, 1'b1, 1'b0);
    drv(b);
    repeat (n) @(posedge ref_clk);
    rd(OFS_STATUS, {e, 16'h0}, 32'hFFFF0000);
    st(1'b0, 1'b0, 1'b0);
    drv(8'h00);
    repeat (n) @(posedge ref_clk);
  endtask

  initial
  begin
    logic [15:0] r;
    void'($urandom(85553));
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(OFS_CTRL, 32'h10760214, 32'hFFFFFFFF);
    rd(OFS_JOG_ONE, 32'h00000096, 32'hFFFFFFFF);
    rd(OFS_JOG_TWO, 32'h0000FF6A, 32'hFFFFFFFF);
    rd(OFS_CEILING, 32'h000005DC, 32'hFFFFFFFF);
    rd(OFS_RAMP_UP, 32'h00002710, 32'hFFFFFFFF);
    rd(OFS_RAMP_DOWN, 32'h00002710, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
      rd(OFS_SRC_BASE + 8'(4 * i), 32'h00000210, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    // Preset wiring: enable, ON, reversing on inputs 0, 1, 2
    drv(8'h01);
    st(1'b1, 1'b1, 1'b0);
    drv(8'h03);
    st(1'b0, 1'b0, 1'b0);
    drv(8'h02);
    drv(8'h03);
    drv(8'h05);
    st(1'b1, 1'b1, 1'b1);
    drv(8'h07);
    st(1'b0, 1'b0, 1'b0);
    drv(8'h06);
    drv(8'h00);
    // Routed sources: enable 5, ON 4, reversing 3; jog on inputs 0 and 1
    wb(1'b1, OFS_CTRL, 32'h10760200);
    wb(1'b1, OFS_SRC_BASE, 32'h00000345);
    wb(1'b1, OFS_RAMP_UP, 32'h0);
    wb(1'b1, OFS_RAMP_DOWN, 32'h0);
    jog_mask <= 8'h03;
    drv(8'h20);
    st(1'b1, 1'b1, 1'b0);
    drv(8'h30);
    force_jog <= 1'b1;
    drv(8'h31);
    repeat (1100) @(posedge ref_clk);
    rd(OFS_STATUS, {RUN_SPEED_RST, 16'h0}, 32'hFFFF0000);
    force_jog <= 1'b0;
    drv(8'h30);
    st(1'b0, 1'b0, 1'b0);
    drv(8'h10);
    drv(8'h00);
    repeat (1100) @(posedge ref_clk);
    jog(8'h01, 300, JOG_ONE_RST);
    wb(1'b1, OFS_CTRL, 32'h10760A00);
    jog(8'h02, 300, 16'h0096);
    wb(1'b1, OFS_CTRL, 32'h10761200);
    jog(8'h02, 300, 16'h0000);
    wb(1'b1, OFS_CTRL, 32'h10760200);
    r = 16'($urandom_range(2500, 1));
    wb(1'b1, OFS_JOG_ONE, {16'h0, r});
    jog(8'h01, 1600, (r > CEILING_RST) ? CEILING_RST : r);
    // Command set selector on inputs 6 and 7
    jog_mask <= 8'h00;
    drv(8'h40);
    rd(OFS_STATUS, 32'h0, 32'h0000000C);
    repeat (30) @(posedge ref_clk);
    rd(OFS_STATUS, 32'h4, 32'h0000000C);
    drv(8'hC0);
    repeat (30) @(posedge ref_clk);
    rd(OFS_STATUS, 32'h4, 32'h0000000C);
    wb(1'b1, OFS_CTRL, 32'h10760400);
    repeat (30) @(posedge ref_clk);
    rd(OFS_STATUS, 32'hC, 32'h0000000C);
    wb(1'b1, OFS_CTRL, 32'h10760700);
    rd(OFS_CTRL, 32'h10760400, 32'hFFFFFFFF);
    drv(8'h00);
    if (rd_q.size() > 0 || st_q.size() > 0)
      n_errors++;
    results;
  end
endmodule
`default_nettype wire
